// *** verilog/drc_pkg.sv ***
// Package: constants for the ramp and converter calibration register group
package drc_pkg;
    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SECOND_CTRL = 8'h01;
    localparam logic [7:0] ADDR_FOURTH_CTRL = 8'h03;
    localparam logic [7:0] ADDR_RAMP_LOWER = 8'h04;
    localparam logic [7:0] ADDR_RAMP_UPPER = 8'h05;
    localparam logic [7:0] ADDR_RAMP_RISE = 8'h06;
    localparam logic [7:0] ADDR_RAMP_FALL = 8'h07;
    localparam logic [7:0] ADDR_RAMP_RATE = 8'h08;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int LOCK_BIT = 24;
    localparam int RAMP_EN_BIT = 19;
    localparam int SYNC_PD_BIT = 26;
    localparam int CAL_CLK_PD_BIT = 25;
    localparam int CAL_START_BIT = 24;
    localparam int RATE_FALL_LSB = 16;
    localparam int RATE_W = 16;
    // ---------------------------------------------------------------
    // Reset values and lock window
    // ---------------------------------------------------------------
    localparam logic [31:0] FOURTH_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [31:0] FOURTH_CTRL_MASK = 32'h07ff_ffff;
    localparam logic [10:0] LDW_CYC_128 = 11'h080;
    localparam logic [10:0] LDW_CYC_256 = 11'h100;
    localparam logic [10:0] LDW_CYC_512 = 11'h200;
    localparam logic [10:0] LDW_CYC_1024 = 11'h400;
    localparam int CAL_CYCLES = 16;
endpackage : drc_pkg

// *** verilog/drc_lock_if.sv ***
// Interface: lock detector window select and result
`timescale 1ns/10ps
interface drc_lock_if;
    logic [1:0] window;
    logic locked;
    modport det (input window, output locked);
    modport ctl (output window, input locked);
endinterface : drc_lock_if

// *** verilog/drc_lock_det.sv ***
// Lock detector: counts reference cycles with phase error in range
`timescale 1ns/10ps
module drc_lock_det
    import drc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ref_tick,
    input wire logic phase_in_range,
    drc_lock_if.det lk
);
    logic [10:0] cnt_q, cnt_d;
    logic lock_q, lock_d;
    logic [10:0] need;

    always_comb begin
        unique case (lk.window)
            2'b00: need = LDW_CYC_128;
            2'b01: need = LDW_CYC_256;
            2'b10: need = LDW_CYC_512;
            2'b11: need = LDW_CYC_1024;
        endcase
    end

    always_comb begin
        cnt_d = cnt_q;
        lock_d = lock_q;
        if (!phase_in_range) begin
            // Any excursion restarts the in-range interval
            cnt_d = '0;
            lock_d = 1'b0;
        end else if (ref_tick) begin
            if (cnt_q >= need - 11'h001) begin
                lock_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 11'h001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_q <= '0;
            lock_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            lock_q <= lock_d;
        end
    end

    assign lk.locked = lock_q;
endmodule : drc_lock_det

// *** verilog/drc_regs.sv ***
// Top: ramp and converter calibration register group
// Notes on behaviour
// - Window code 11 needs 1024 reference cycles
// - Codes 00/01/10 need 128/256/512 cycles
// - Lock status readable at bit 24, address 0x00
// - Bit 26 set disables sync output
// - Calibration clock runs only if bits 25,26 clear
// - Writing bit 24 one starts converter calibration
// - Ramp registers apply only while ramp enabled
// - Address 0x04 holds 32-bit lower bound
// - Address 0x05 holds 32-bit upper bound
// - Address 0x06 holds rising step amount
// - Address 0x07 holds falling step amount
// - Rate bits 31..16 set falling step interval
// - Rate bits 15..0 set rising step interval
`timescale 1ns/10ps
module drc_regs
    import drc_pkg::*;
#(
    parameter int CAL_LEN = CAL_CYCLES
)(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    input wire logic [31:0] second_control_word,
    input wire logic [1:0] lock_detect_window,
    input wire logic ref_tick,
    input wire logic phase_in_range,
    output logic sync_out_enable,
    output logic cal_clk_enable,
    output logic cal_busy,
    output logic ramp_active,
    output logic [31:0] ramp_lower,
    output logic [31:0] ramp_upper,
    output logic [31:0] ramp_rise_step,
    output logic [31:0] ramp_fall_step,
    output logic [15:0] ramp_rise_interval,
    output logic [15:0] ramp_fall_interval
);
    // Calibration counter is 16 bits wide
    if (CAL_LEN < 1 || CAL_LEN > 65535) begin : g_bad_len
        $error("CAL_LEN out of range");
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    logic [31:0] ctl4_q, ctl4_d;
    logic [31:0] low_q, low_d;
    logic [31:0] up_q, up_d;
    logic [31:0] rise_q, rise_d;
    logic [31:0] fall_q, fall_d;
    logic [31:0] rate_q, rate_d;
    logic [31:0] rdata_q, rdata_d;
    logic cal_q, cal_d;
    logic [15:0] calcnt_q, calcnt_d;
    logic ramp_en;
    logic cal_clk_on;
    logic [31:0] olow_q, olow_d;
    logic [31:0] oup_q, oup_d;
    logic [31:0] orise_q, orise_d;
    logic [31:0] ofall_q, ofall_d;
    logic [15:0] orise_ivl_q, orise_ivl_d;
    logic [15:0] ofall_ivl_q, ofall_ivl_d;

    drc_lock_if lk ();
    assign lk.window = lock_detect_window;

    drc_lock_det u_lock (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ref_tick(ref_tick),
        .phase_in_range(phase_in_range),
        .lk(lk)
    );

    assign ramp_en = second_control_word[RAMP_EN_BIT];
    assign cal_clk_on = ~ctl4_q[CAL_CLK_PD_BIT]
                        & ~ctl4_q[SYNC_PD_BIT];

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    always_comb begin
        ctl4_d = ctl4_q;
        low_d = low_q;
        up_d = up_q;
        rise_d = rise_q;
        fall_d = fall_q;
        rate_d = rate_q;
        if (reg_wr) begin
            unique case (reg_addr)
                // Start bit is self-clearing, so it is not stored
                ADDR_FOURTH_CTRL: ctl4_d = reg_wdata & FOURTH_CTRL_MASK
                    & ~(32'h0000_0001 << CAL_START_BIT);
                ADDR_RAMP_LOWER: low_d = reg_wdata;
                ADDR_RAMP_UPPER: up_d = reg_wdata;
                ADDR_RAMP_RISE: rise_d = reg_wdata;
                ADDR_RAMP_FALL: fall_d = reg_wdata;
                ADDR_RAMP_RATE: rate_d = reg_wdata;
                default: ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Calibration sequencer
    // ---------------------------------------------------------------
    always_comb begin
        cal_d = cal_q;
        calcnt_d = calcnt_q;
        if (reg_wr && reg_addr == ADDR_FOURTH_CTRL
            && reg_wdata[CAL_START_BIT]) begin
            cal_d = 1'b1;
            calcnt_d = '0;
        end else if (cal_q && cal_clk_on) begin
            // Calibration only advances while its clock runs
            if (calcnt_q == 16'(CAL_LEN - 1)) begin
                cal_d = 1'b0;
            end else begin
                calcnt_d = calcnt_q + 16'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Read mux
    // ---------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_STATUS: rdata_d = 32'(lk.locked) << LOCK_BIT;
                ADDR_FOURTH_CTRL: rdata_d = ctl4_q;
                ADDR_RAMP_LOWER: rdata_d = low_q;
                ADDR_RAMP_UPPER: rdata_d = up_q;
                ADDR_RAMP_RISE: rdata_d = rise_q;
                ADDR_RAMP_FALL: rdata_d = fall_q;
                ADDR_RAMP_RATE: rdata_d = rate_q;
                default: rdata_d = WORD_RST;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ctl4_q <= FOURTH_CTRL_RST;
            low_q <= WORD_RST;
            up_q <= WORD_RST;
            rise_q <= WORD_RST;
            fall_q <= WORD_RST;
            rate_q <= WORD_RST;
        end else begin
            ctl4_q <= ctl4_d;
            low_q <= low_d;
            up_q <= up_d;
            rise_q <= rise_d;
            fall_q <= fall_d;
            rate_q <= rate_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cal_q <= 1'b0;
            calcnt_q <= '0;
        end else begin
            cal_q <= cal_d;
            calcnt_q <= calcnt_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata_q <= WORD_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ---------------------------------------------------------------
    // Ramp output staging
    // ---------------------------------------------------------------
    // Taken from the next register values, so a write made while the
    // ramp runs reaches the generator on the edge that stores it.
    // Zero while the ramp is off; the stored words stay untouched.
    always_comb begin
        olow_d = WORD_RST;
        oup_d = WORD_RST;
        orise_d = WORD_RST;
        ofall_d = WORD_RST;
        ofall_ivl_d = '0;
        orise_ivl_d = '0;
        if (ramp_en) begin
            olow_d = low_d;
            oup_d = up_d;
            orise_d = rise_d;
            ofall_d = fall_d;
            ofall_ivl_d = rate_d[RATE_FALL_LSB +: RATE_W];
            orise_ivl_d = rate_d[0 +: RATE_W];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            olow_q <= WORD_RST;
            oup_q <= WORD_RST;
            orise_q <= WORD_RST;
            ofall_q <= WORD_RST;
            ofall_ivl_q <= '0;
            orise_ivl_q <= '0;
        end else begin
            olow_q <= olow_d;
            oup_q <= oup_d;
            orise_q <= orise_d;
            ofall_q <= ofall_d;
            ofall_ivl_q <= ofall_ivl_d;
            orise_ivl_q <= orise_ivl_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign sync_out_enable = ~ctl4_q[SYNC_PD_BIT];
    assign cal_clk_enable = cal_clk_on;
    assign cal_busy = cal_q;
    assign ramp_active = ramp_en;
    assign ramp_lower = olow_q;
    assign ramp_upper = oup_q;
    assign ramp_rise_step = orise_q;
    assign ramp_fall_step = ofall_q;
    assign ramp_fall_interval = ofall_ivl_q;
    assign ramp_rise_interval = orise_ivl_q;
endmodule : drc_regs

// *** verif/drc_regs_sva.sv ***
// Checker for the register group ports
`timescale 1ns/10ps
module drc_regs_sva
    import drc_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic [31:0] second_control_word,
    input wire logic sync_out_enable,
    input wire logic cal_clk_enable,
    input wire logic cal_busy,
    input wire logic [31:0] ramp_lower,
    input wire logic [15:0] ramp_rise_interval,
    input wire logic [15:0] ramp_fall_interval
);
    wire ramp_en = second_control_word[RAMP_EN_BIT];
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    sequence ctl_wr;
        reg_wr && reg_addr == ADDR_FOURTH_CTRL;
    endsequence
    sequence ramp_on;
        ramp_en && $past(ramp_en);
    endsequence
    sync_gate_a: assert property (ctl_wr |=>
        sync_out_enable == !$past(reg_wdata[SYNC_PD_BIT]))
        else $error("bad sync gate");
    cal_gate_a: assert property (ctl_wr |=>
        cal_clk_enable == ($past(reg_wdata[26:25]) == 2'h0))
        else $error("bad cal clock");
    cal_start_a: assert property (ctl_wr ##0
        reg_wdata[26:24] == 3'h1 |=> cal_busy) else $error("no cal");
    cal_pause_a: assert property (cal_busy && !cal_clk_enable
        |=> cal_busy) else $error("cal aborted");
    ramp_off_a: assert property (!ramp_en && !$past(ramp_en) |->
        ramp_lower == '0 && ramp_rise_interval == '0)
        else $error("ramp not gated");
    ramp_low_a: assert property (ramp_on ##0 $past(reg_wr) &&
        $past(reg_addr) == ADDR_RAMP_LOWER |-> ramp_lower == $past(reg_wdata))
        else $error("bad lower");
    ramp_rate_a: assert property (ramp_on ##0 $past(reg_wr) &&
        $past(reg_addr) == ADDR_RAMP_RATE |->
        {ramp_fall_interval, ramp_rise_interval} == $past(reg_wdata))
        else $error("bad rate");
    rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved");
endmodule : drc_regs_sva
bind drc_regs drc_regs_sva i_drc_regs_sva (.*);

// *** verif/drc_host_model.sv ***
// Host model: drives the programming port from the far side
`timescale 1ns/10ps
module drc_host_model
    import drc_pkg::*;
(
    input wire logic mclk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
    end
    // Strobe spans one rising edge; data inverted after, never stale
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask : xfer
    task automatic ctl(input logic [2:0] pd);
        xfer(1'b1, ADDR_FOURTH_CTRL,
            {5'h0, pd, FOURTH_CTRL_RST[23:0]});
    endtask : ctl
endmodule : drc_host_model

// *** verif/tb_top.sv ***
// Testbench for the ramp and calibration register group
`timescale 1ns/10ps
module tb_top;
    import drc_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [31:0] second_control_word = 32'h0;
    logic [1:0] lock_detect_window = 2'h0;
    logic ref_tick = 1'b0;
    logic phase_in_range = 1'b0;
    logic reg_wr, reg_rd, sync_out_enable, cal_clk_enable, cal_busy, rd_s;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, ramp_lower;
    logic [15:0] ramp_rise_interval, ramp_fall_interval;
    logic ramp_active;
    logic [31:0] ramp_upper, ramp_rise_step, ramp_fall_step;
    logic [31:0] expq[$];
    logic [31:0] val[9];
    int num_errors = 0;
    int checks_done = 0;
    always #25 mclk = ~mclk;
    drc_regs #(.CAL_LEN(2)) i_drc_regs (.*);
    drc_host_model i_drc_host_model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        i_drc_host_model.xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic ticks(input int n);
        repeat (n) begin
            @(negedge mclk) ref_tick = 1'b1;
            @(negedge mclk) ref_tick = 1'b0;
        end
    endtask : ticks
    task automatic test_done;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    task automatic wait_idle;
        for (int n = 0; cal_busy !== 1'b0; n++) begin
            if (n > 40) begin
                num_errors++;
                test_done();
            end
            @(negedge mclk);
        end
    endtask : wait_idle
    // ---------------------------------------------------------------
    // Read checker: data is registered on the read edge and checked on the next falling edge
    // ---------------------------------------------------------------
    always @(posedge mclk) rd_s <= reg_rd;
    always @(negedge mclk) begin
        if (rd_s) begin
            chk(reg_rdata, expq.pop_front());
        end
    end
    initial begin
        // Bounded well above the run length, about 0.2 ms
        #4ms;
        num_errors++;
        test_done();
    end
    initial begin
        void'($urandom(32'h31d3));
        repeat (5) @(negedge mclk);
        sys_rst = 1'b0;
        i_drc_host_model.ctl(3'h1);
        chk({31'h0, cal_busy}, 32'h1);
        wait_idle();
        for (int p = 0; p < 8; p++) begin
            i_drc_host_model.ctl(p[2:0]);
            chk({sync_out_enable, cal_clk_enable},
                {~p[2], ~p[2] & ~p[1]});
            rd(ADDR_FOURTH_CTRL, {5'h0, p[2:1], 25'h0});
        end
        i_drc_host_model.ctl(3'h0);
        wait_idle();
        for (int a = 4; a < 9; a++) begin
            val[a] = $urandom;
            i_drc_host_model.xfer(1'b1, a[7:0], val[a]);
        end
        i_drc_host_model.xfer(1'b1, 8'h09, 32'hffff_ffff);
        rd(8'h09, 32'h0);
        rd(8'h02, 32'h0);
        chk(ramp_lower, 32'h0);
        chk({31'h0, ramp_active}, 32'h0);
        chk(ramp_upper | ramp_rise_step | ramp_fall_step, 32'h0);
        chk({ramp_fall_interval, ramp_rise_interval}, 32'h0);
        second_control_word[RAMP_EN_BIT] = 1'b1;
        for (int a = 4; a < 9; a++) rd(a[7:0], val[a]);
        chk(ramp_lower, val[4]);
        chk({ramp_fall_interval, ramp_rise_interval}, val[8]);
        chk({31'h0, ramp_active}, 32'h1);
        chk(ramp_upper, val[5]);
        chk(ramp_rise_step, val[6]);
        chk(ramp_fall_step, val[7]);
        i_drc_host_model.xfer(1'b1, ADDR_RAMP_RATE, ~val[8]);
        i_drc_host_model.xfer(1'b1, ADDR_RAMP_LOWER, ~val[4]);
        chk(ramp_lower, ~val[4]);
        chk({ramp_fall_interval, ramp_rise_interval}, ~val[8]);
        for (int c = 0; c < 4; c++) begin
            lock_detect_window = c[1:0];
            phase_in_range = 1'b1;
            ticks((128 << c) - 1);
            rd(ADDR_STATUS, 32'h0);
            ticks(2);
            rd(ADDR_STATUS, 32'h0100_0000);
            phase_in_range = 1'b0;
            rd(ADDR_STATUS, 32'h0);
        end
        repeat (3) @(negedge mclk);
        test_done();
    end
endmodule : tb_top
